// *** gas_status_pkg.sv ***
// gas sensor status flags: shared constants and types
// assumes one system clock; all users write gas_status_pkg::name
package gas_status_pkg;
  // measured-data and status area
  localparam logic [7:0] AREA_FIRST = 8'h9A;
  localparam logic [7:0] AREA_LAST  = 8'hAB;
  localparam int         AREA_BYTES = 18;
  // status byte indices inside the area
  localparam logic [4:0] IDX_PRIM   = 5'h0E;
  localparam logic [4:0] IDX_SUPP   = 5'h0F;
  localparam logic [4:0] IDX_UNF    = 5'h10;
  localparam logic [4:0] IDX_FIL    = 5'h11;
  // primary error byte fields
  localparam int B_FATAL = 0;
  localparam int B_RSVD  = 1;
  localparam int B_ALG   = 2;
  localparam int B_CAL   = 3;
  localparam int B_DIAG  = 4;
  localparam int B_RANGE = 5;
  localparam int B_MEM   = 6;
  localparam int B_FACT  = 7;
  // supply and converter byte fields
  localparam int S_PRE   = 0;
  localparam int S_INR   = 1;
  localparam int S_ADC   = 2;
  localparam int S_OVR   = 4;
  // stage bytes hold stage flags in bits 3..0
  localparam int G_W     = 4;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // broadcast address and fixed write reply
  localparam logic [7:0] BCAST_ADDR = 8'hFE;
  localparam logic [7:0] CC_INITIAL = 8'h10;
  localparam int         RESP_LEN   = 4;
  localparam logic [31:0] RESP_FRAME = 32'hFE41_0080; // arbitrary bytes, first byte in top
  // error causes seen during one measurement cycle
  typedef struct packed {
    logic       cfg_corrupt;
    logic       vmem_fail;
    logic       cap_meas_fail;
    logic       alg_param_bad;
    logic       cal_oor;
    logic       self_check_fault;
    logic       page_csum_fail;
    logic       flash_fail;
    logic       prepulse_supply_low;
    logic       inrush_supply_low;
    logic       adc_oor;
    logic [3:0] unf_stage;
    logic [3:0] fil_stage;
  } err_src_t;
  typedef struct packed {
    logic [7:0] prim;
    logic [7:0] supp;
    logic [7:0] unf;
    logic [7:0] fil;
  } status_t;
endpackage

// *** status_area_mem.sv ***
// status_area_mem: small byte store for the measured-data area
// one write port, one read port, read data from a register
`timescale 1ns/1ps
module status_area_mem #(
  parameter int W  = 8,
  parameter int D  = 18,
  parameter int AW = 5
) (
  // clock
  input  wire logic          sys_clk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);
  initial begin
    if (D > (1 << AW)) $error("depth exceeds address range");
  end
  logic [W-1:0] mem [D];
  // write and registered read
  always_ff @(posedge sys_clk) begin
    if (we && (int'(waddr) < D)) mem[waddr] <= wdata;
    if (re) rdata_q <= mem[raddr];
  end
endmodule

// *** gas_sensor_error_status.sv ***
// gas_sensor_error_status: collects error causes of one measurement
// cycle into four read-only status bytes inside the data area
// assumes all inputs come from logic on sys_clk
//
// Functional notes
// RULE1: primary bit 0 is set on config corruption, memory access or cap fault.
// RULE2: primary bit 2 is set when algorithm config is corrupt or out of range.
// RULE3: primary bit 3 is set when a calibration or baseline correction fails.
// RULE4: primary bit 4 is set when self-check finds hardware or parameter faults.
// RULE5: primary bit 5 follows any stage range violation and clears when gone.
// RULE6: primary bit 6 is set on page checksum or flash operation failure.
// RULE7: primary bit 7 always reads zero in customer operation.
// RULE8: supply bit 0 is set when pre-pulse supply is below its threshold.
// RULE9: supply bit 1 is set when inrush average supply is below threshold.
// RULE10: supply bit 2 is set when the converter reports out of range.
// RULE11: supply bits 4-7 show debug overrides, zero normally; bit 3 reserved.
// RULE12: stage bytes hold unfiltered and filtered range stage flags in bits 3-0.
// RULE13: stage bit 0 marks the raw emitter signal out of baseline.
// RULE14: stage bit 1 marks temperature compensation out of specification.
// RULE15: stage bit 2 marks a missing conversion table entry.
// RULE16: stage bit 3 marks host pressure value out of specification.
// RULE17: every good broadcast write gets the same fixed reply frame; one arriving while a reply is being sent gets none.
// RULE18: host power-cycles and restarts with initial measurement on fatal errors.
// RULE19: status bytes sit inside the 18-byte area at 0x9A to 0xAB.
// RULE20: host writes 0x10 to the calculation control byte to start fresh; here CC_INITIAL is unused and the bench restarts by reset.
// RULE21: status bytes are read-only, updated together before ready rises.
`timescale 1ns/1ps
module gas_sensor_error_status #(
  parameter int AREA_BYTES = gas_status_pkg::AREA_BYTES,
  parameter int RESP_LEN   = gas_status_pkg::RESP_LEN
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  // measurement cycle
  input  wire logic                      cycle_start,
  input  wire logic                      cycle_end,
  input  wire gas_status_pkg::err_src_t  err_src,
  input  wire logic                      dbg_mode,
  input  wire logic [3:0]                dbg_override,
  output logic                           ready_q,
  // measured data from the algorithm
  input  wire logic                      data_we,
  input  wire logic [4:0]                data_idx,
  input  wire logic [7:0]                data_byte,
  // host read of the data area
  input  wire logic                      rd_en,
  input  wire logic [7:0]                rd_addr,
  output logic [7:0]                     rd_data,
  output logic                           rd_valid_q,
  output logic                           rd_err_q,
  // broadcast write reply
  input  wire logic                      wr_done,
  input  wire logic [7:0]                wr_dev_addr,
  input  wire logic                      wr_ok,
  output logic                           resp_valid,
  output logic [7:0]                     resp_byte_q,
  output logic                           resp_last,
  input  wire logic                      resp_ready,
  // status bytes as last committed
  output gas_status_pkg::status_t        status_q
);
  initial begin
    if (AREA_BYTES != 18) $error("area must be 18 bytes");
    if (RESP_LEN < 1 || RESP_LEN > 4) $error("reply length 1..4");
  end

  // ----------------------------------------
  // cycle sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, MEAS, COMMIT, READY} cyc_t;
  cyc_t       state_q;
  logic [1:0] wcnt_q;

  // idle, measure, write four bytes, ready
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
    end else begin
      unique case (state_q)
        IDLE:   if (cycle_start) state_q <= MEAS;
        MEAS:   if (cycle_end) state_q <= COMMIT;
        COMMIT: if (wcnt_q == 2'h3) state_q <= READY;
        READY:  if (cycle_start) state_q <= MEAS;
      endcase
    end
  end

  // byte counter while committing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) wcnt_q <= 2'h0;
    else if (state_q == COMMIT) wcnt_q <= wcnt_q + 2'h1;
    else wcnt_q <= 2'h0;
  end

  // ready after all four bytes are stored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ready_q <= 1'b0;
    else if (state_q == COMMIT && wcnt_q == 2'h3) ready_q <= 1'b1; // RULE21
    else if (cycle_start) ready_q <= 1'b0;
  end

  // ----------------------------------------
  // error accumulation
  // ----------------------------------------
  gas_status_pkg::err_src_t acc_q;
  logic                     meas;
  assign meas = (state_q == MEAS);

  // sticky within a cycle, cleared at start; a cause on start still counts
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) acc_q <= '0;
    else if (cycle_start) acc_q <= err_src;
    else if (meas) acc_q <= acc_q | err_src;
  end

  // ----------------------------------------
  // status byte composition
  // ----------------------------------------
  gas_status_pkg::status_t nxt;
  logic                    any_stage;
  assign any_stage = |{acc_q.unf_stage, acc_q.fil_stage};

  always_comb begin
    nxt = '0;
    nxt.prim[gas_status_pkg::B_FATAL] = acc_q.cfg_corrupt | acc_q.vmem_fail
                                      | acc_q.cap_meas_fail; // RULE1
    nxt.prim[gas_status_pkg::B_ALG]   = acc_q.alg_param_bad; // RULE2
    nxt.prim[gas_status_pkg::B_CAL]   = acc_q.cal_oor; // RULE3
    nxt.prim[gas_status_pkg::B_DIAG]  = acc_q.self_check_fault; // RULE4
    nxt.prim[gas_status_pkg::B_RANGE] = any_stage; // RULE5
    nxt.prim[gas_status_pkg::B_MEM]   = acc_q.page_csum_fail | acc_q.flash_fail; // RULE6
    nxt.prim[gas_status_pkg::B_FACT]  = 1'b0; // RULE7
    nxt.prim[gas_status_pkg::B_RSVD]  = 1'b0;
    nxt.supp[gas_status_pkg::S_PRE]   = acc_q.prepulse_supply_low; // RULE8
    nxt.supp[gas_status_pkg::S_INR]   = acc_q.inrush_supply_low; // RULE9
    nxt.supp[gas_status_pkg::S_ADC]   = acc_q.adc_oor; // RULE10
    nxt.supp[gas_status_pkg::S_OVR +: 4] = dbg_mode ? dbg_override : 4'h0; // RULE11
    nxt.unf[gas_status_pkg::G_W-1:0]  = acc_q.unf_stage; // RULE12 RULE13 RULE14 RULE15 RULE16
    nxt.fil[gas_status_pkg::G_W-1:0]  = acc_q.fil_stage; // RULE12
  end

  // all four bytes latched together on the last measuring cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) status_q <= '0;
    else if (meas && cycle_end) status_q <= nxt; // RULE21
  end

  // ----------------------------------------
  // data area storage
  // ----------------------------------------
  logic       m_we;
  logic [4:0] m_waddr;
  logic [7:0] m_wdata;
  logic       in_area;
  logic [4:0] m_raddr;

  // status bytes written during commit, algorithm data otherwise
  always_comb begin
    m_we    = data_we && (state_q != COMMIT);
    m_waddr = data_idx;
    m_wdata = data_byte;
    if (state_q == COMMIT) begin
      m_we = 1'b1;
      unique case (wcnt_q)
        2'h0: begin
          m_waddr = gas_status_pkg::IDX_PRIM; // RULE19
          m_wdata = status_q.prim;
        end
        2'h1: begin
          m_waddr = gas_status_pkg::IDX_SUPP;
          m_wdata = status_q.supp;
        end
        2'h2: begin
          m_waddr = gas_status_pkg::IDX_UNF;
          m_wdata = status_q.unf;
        end
        2'h3: begin
          m_waddr = gas_status_pkg::IDX_FIL;
          m_wdata = status_q.fil;
        end
      endcase
    end
  end

  // host address to byte index; nothing outside the area is readable
  assign in_area = (rd_addr >= gas_status_pkg::AREA_FIRST)
                && (rd_addr <= gas_status_pkg::AREA_LAST); // RULE19
  assign m_raddr = 5'(rd_addr - gas_status_pkg::AREA_FIRST);

  status_area_mem #(
    .W  (8),
    .D  (AREA_BYTES),
    .AW (5)
  ) u_area (
    .sys_clk (sys_clk),
    .we      (m_we),
    .waddr   (m_waddr),
    .wdata   (m_wdata),
    .re      (rd_en && in_area),
    .raddr   (m_raddr),
    .rdata_q (rd_data)
  );

  // read answer one cycle after the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid_q <= 1'b0;
      rd_err_q   <= 1'b0;
    end else begin
      rd_valid_q <= rd_en && in_area;
      rd_err_q   <= rd_en && !in_area;
    end
  end

  // ----------------------------------------
  // fixed broadcast write reply
  // ----------------------------------------
  logic [1:0] rcnt_q;
  logic       rbusy_q;
  logic       bcast_hit;
  assign bcast_hit = wr_done && wr_ok && (wr_dev_addr == gas_status_pkg::BCAST_ADDR);

  // reply sequencer; a new request during a reply is ignored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rbusy_q <= 1'b0;
      rcnt_q  <= 2'h0;
    end else if (!rbusy_q) begin
      rbusy_q <= bcast_hit; // RULE17
      rcnt_q  <= 2'h0;
    end else if (resp_ready) begin
      rcnt_q <= rcnt_q + 2'h1;
      if (resp_last) rbusy_q <= 1'b0;
    end
  end

  // reply byte from the constant frame
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) resp_byte_q <= 8'h00;
    else if (!rbusy_q) resp_byte_q <= gas_status_pkg::RESP_FRAME[31:24]; // RULE17
    else if (resp_ready && !resp_last)
      resp_byte_q <= gas_status_pkg::RESP_FRAME[8*(2-int'(rcnt_q)) +: 8];
  end

  assign resp_valid = rbusy_q;
  assign resp_last  = rbusy_q && (int'(rcnt_q) == RESP_LEN - 1);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_fatal_combine: assert property ( // RULE1
    meas && cycle_end |=> status_q.prim[0] ==
      $past(acc_q.cfg_corrupt | acc_q.vmem_fail | acc_q.cap_meas_fail))
    else $error("fatal flag mismatch");
  a_alg_flag: assert property ( // RULE2
    meas && cycle_end |=> status_q.prim[2] == $past(acc_q.alg_param_bad))
    else $error("algorithm flag mismatch");
  a_cal_flag: assert property ( // RULE3
    meas && cycle_end && acc_q.cal_oor |=> status_q.prim[3])
    else $error("calibration flag missing");
  a_diag_flag: assert property ( // RULE4
    meas && cycle_end |=> status_q.prim[4] == $past(acc_q.self_check_fault))
    else $error("self-check flag mismatch");
  a_range_clears: assert property ( // RULE5
    cycle_start && err_src.unf_stage == 4'h0 && err_src.fil_stage == 4'h0
    ##1 (meas && err_src.unf_stage == 4'h0 && err_src.fil_stage == 4'h0 && !cycle_end) [*2]
    ##1 meas && cycle_end && !any_stage |=> !status_q.prim[5])
    else $error("range flag did not clear");
  a_mem_flag: assert property ( // RULE6
    meas && cycle_end |=> status_q.prim[6] ==
      $past(acc_q.page_csum_fail | acc_q.flash_fail))
    else $error("memory flag mismatch");
  a_factory_zero: assert property (!status_q.prim[7] && !status_q.prim[1]) // RULE7
    else $error("factory or reserved bit set");
  a_supply_flags: assert property ( // RULE8
    meas && cycle_end |=> status_q.supp[2:0] == $past({acc_q.adc_oor,
      acc_q.inrush_supply_low, acc_q.prepulse_supply_low}))
    else $error("supply flags mismatch");
  a_override_idle: assert property ( // RULE11
    meas && cycle_end && !dbg_mode |=> status_q.supp[7:3] == 5'h00)
    else $error("override bits set outside debug");
  a_stage_bytes: assert property ( // RULE12
    meas && cycle_end |=> status_q.unf == {4'h0, $past(acc_q.unf_stage)}
      && status_q.fil == {4'h0, $past(acc_q.fil_stage)})
    else $error("stage bytes mismatch");
  a_ready_after: assert property ( // RULE21
    meas && cycle_end |=> !ready_q [*4] ##1 ready_q && $stable(status_q))
    else $error("ready timing wrong");
  a_reply_fixed: assert property ( // RULE17
    !rbusy_q && bcast_hit |=> resp_valid && resp_byte_q == 8'hFE)
    else $error("broadcast reply wrong");
  a_read_window: assert property ( // RULE19
    rd_en && !in_area |=> rd_err_q && !rd_valid_q)
    else $error("out of area read accepted");
  a_read_accept: assert property ( // RULE19
    rd_en && in_area |=> rd_valid_q && !rd_err_q)
    else $error("in area read refused");
  a_commit_index: assert property ( // RULE19
    state_q == COMMIT |-> m_we && m_waddr == gas_status_pkg::IDX_PRIM + 5'(wcnt_q))
    else $error("status byte stored at wrong index");

  // remaining flag bits
  a_inrush_flag: assert property ( // RULE9
    meas && cycle_end |=> status_q.supp[1] == $past(acc_q.inrush_supply_low))
    else $error("inrush flag mismatch");
  a_adc_flag: assert property ( // RULE10
    meas && cycle_end |=> status_q.supp[2] == $past(acc_q.adc_oor))
    else $error("converter flag mismatch");
  a_supply_rsvd: assert property (!status_q.supp[3]) // RULE11
    else $error("reserved supply bit set");
  a_range_sets: assert property ( // RULE5
    meas && cycle_end && any_stage |=> status_q.prim[5])
    else $error("range flag missing");
  a_stage_upper: assert property ( // RULE12
    status_q.unf[7:4] == 4'h0 && status_q.fil[7:4] == 4'h0)
    else $error("stage byte upper bits set");

  // commit and ready timing
  a_status_hold: assert property ( // RULE21
    !(meas && cycle_end) |=> $stable(status_q))
    else $error("status bytes changed mid cycle");
  a_ready_holds: assert property ( // RULE21
    ready_q && !cycle_start |=> ready_q)
    else $error("ready dropped without a start");
  a_ready_drop: assert property ( // RULE21
    cycle_start && !(state_q == COMMIT && wcnt_q == 2'h3) |=> !ready_q)
    else $error("ready stayed high after start");

  // reply handshake
  a_reply_holds: assert property ( // RULE17
    resp_valid && !resp_ready |=> resp_valid && $stable(resp_byte_q))
    else $error("reply byte not held");
  a_reply_last: assert property ( // RULE17
    resp_valid && resp_last |-> resp_byte_q == gas_status_pkg::RESP_FRAME[8*(4-RESP_LEN) +: 8])
    else $error("last reply byte wrong");

  // main scenarios
  c_cycle_err: cover property (meas && cycle_end && |nxt.prim ##5 ready_q);
  c_reply_done: cover property (resp_valid && resp_last && resp_ready);
  c_area_read: cover property (rd_en && rd_addr == 8'hA8 ##1 rd_valid_q);
  c_slow_reply: cover property (resp_valid && !resp_ready ##1 resp_valid && resp_ready);
  c_debug_cycle: cover property (meas && cycle_end && dbg_mode ##5 ready_q);
endmodule

// *** host_model.sv ***
// host_model: host side of area reads and broadcast write replies
// assumes the bench calls its tasks from one process on sys_clk
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       sys_clk,
  // area read
  output logic            rd_en,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid_q,
  input  wire logic       rd_err_q,
  // write completion and reply
  output logic            wr_done,
  output logic [7:0]      wr_dev_addr,
  output logic            wr_ok,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_byte_q,
  input  wire logic       resp_last,
  output logic            resp_ready,
  // reply pacing
  input  wire logic       slow
);
  logic [31:0] frame;
  int          nbytes;
  int          last_n;
  logic        tick;
  initial begin
    {rd_en, rd_addr, wr_done, wr_dev_addr, wr_ok, tick} = '0;
    frame = '0;
    nbytes = 0;
    last_n = 0;
  end
  // slow host accepts a reply byte every other cycle
  assign resp_ready = slow ? tick : 1'b1;
  // reply bytes gathered high byte first
  always @(posedge sys_clk) begin
    tick <= ~tick;
    if (resp_valid && resp_ready) begin
      frame  <= {frame[23:0], resp_byte_q};
      nbytes <= nbytes + 1;
      if (resp_last) last_n <= nbytes + 1;
    end
  end
  // one byte read; released address shows its inverse
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v, output logic e);
    @(posedge sys_clk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge sys_clk);
    rd_en   <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid_q;
    e = rd_err_q;
  endtask
  // finished write request to a device address
  task automatic write_req(input logic [7:0] dev, input logic ok);
    frame  = '0;
    nbytes = 0;
    last_n = 0;
    @(posedge sys_clk);
    wr_done     <= 1'b1;
    wr_dev_addr <= dev;
    wr_ok       <= ok;
    @(posedge sys_clk);
    wr_done     <= 1'b0;
    wr_dev_addr <= ~dev;
    wr_ok       <= ~ok;
  endtask
endmodule

// *** gas_sensor_error_status_tb.sv ***
// gas_sensor_error_status_tb: self-checking bench for the status bytes
// assumes host_model on the host ports and a 125 MHz sys_clk
`timescale 1ns/1ps
module gas_sensor_error_status_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {
    logic [18:0] src;
    logic        dbg;
    logic [3:0]  ov;
    logic [31:0] exp;
  } row_t;
  logic                     sys_clk, resetn, cycle_start, cycle_end, dbg_mode, ready_q;
  logic                     data_we, rd_en, rd_valid_q, rd_err_q, wr_done, wr_ok;
  logic                     resp_valid, resp_last, resp_ready, slow;
  logic [3:0]               dbg_override;
  logic [4:0]               data_idx;
  logic [7:0]               data_byte, rd_addr, rd_data, wr_dev_addr, resp_byte_q;
  gas_status_pkg::err_src_t err_src;
  gas_status_pkg::status_t  status_q;
  row_t                     rows [16];
  int                       fails, checks_done, cyc;
  // ----------------------------------------
  // design, host and clock
  // ----------------------------------------
  gas_sensor_error_status dut (.sys_clk, .resetn, .cycle_start, .cycle_end, .err_src, .dbg_mode,
    .dbg_override, .ready_q, .data_we, .data_idx, .data_byte, .rd_en, .rd_addr, .rd_data,
    .rd_valid_q, .rd_err_q, .wr_done, .wr_dev_addr, .wr_ok, .resp_valid, .resp_byte_q,
    .resp_last, .resp_ready, .status_q);
  host_model host (.sys_clk, .rd_en, .rd_addr, .rd_data, .rd_valid_q, .rd_err_q, .wr_done,
    .wr_dev_addr, .wr_ok, .resp_valid, .resp_byte_q, .resp_last, .resp_ready, .slow);
  always #4 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic area(input logic [7:0] a, input logic [7:0] exp, input logic err);
    logic [7:0] d;
    logic       v, e;
    host.read_byte(a, d, v, e);
    check("rd_err_q", {31'h0, err}, {31'h0, e});
    check("rd_valid_q", {31'h0, ~err}, {31'h0, v});
    if (!err) check("rd_data", {24'h0, exp}, {24'h0, d});
  endtask
  task automatic meas(input row_t r);
    int n;
    @(posedge sys_clk);
    err_src      <= gas_status_pkg::err_src_t'(r.src);
    dbg_mode     <= r.dbg;
    dbg_override <= r.ov;
    cycle_start  <= 1'b1;
    @(posedge sys_clk);
    cycle_start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cycle_end <= 1'b1;
    @(posedge sys_clk);
    cycle_end <= 1'b0;
    err_src   <= '0;
    n = 0;
    while (n < 12) begin
      @(posedge sys_clk);
      n++;
      #1;
      if (ready_q === 1'b1) break;
    end
    check("ready latency", 32'd4, n);
    check("status_q", r.exp, status_q);
    for (int i = 0; i < 4; i++) area(8'hA8 + 8'(i), r.exp[31-8*i -: 8], 1'b0);
  endtask
  task automatic reply(input logic [7:0] dev, input logic ok, input logic [31:0] exp, input int len);
    int n;
    host.write_req(dev, ok);
    n = 0;
    while (n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check("reply frame", exp, host.frame);
    check("reply bytes", len, host.nbytes);
    check("reply last", len, host.last_n);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sys_clk, resetn, cycle_start, cycle_end, dbg_mode, data_we, slow} = '0;
    {dbg_override, data_idx, data_byte} = '0;
    err_src = '0;
    {fails, checks_done, cyc} = '0;
    rows = '{
      '{19'h40000, 1'b0, 4'h0, 32'h0100_0000},
      '{19'h20000, 1'b0, 4'h0, 32'h0100_0000},
      '{19'h10000, 1'b0, 4'h0, 32'h0100_0000},
      '{19'h48000, 1'b0, 4'h0, 32'h0500_0000},
      '{19'h04000, 1'b0, 4'h0, 32'h0800_0000},
      '{19'h42000, 1'b0, 4'h0, 32'h1100_0000},
      '{19'h21000, 1'b0, 4'h0, 32'h4100_0000},
      '{19'h20800, 1'b0, 4'h0, 32'h4100_0000},
      '{19'h00500, 1'b0, 4'h0, 32'h0005_0000},
      '{19'h00200, 1'b0, 4'h0, 32'h0002_0000},
      '{19'h00018, 1'b0, 4'h0, 32'h2000_0108},
      '{19'h00060, 1'b0, 4'h0, 32'h2000_0600},
      '{19'h00000, 1'b0, 4'h0, 32'h0000_0000},
      '{19'h00085, 1'b0, 4'h0, 32'h2000_0805},
      '{19'h00000, 1'b1, 4'hA, 32'h00A0_0000},
      '{19'h00000, 1'b0, 4'hF, 32'h0000_0000}};
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[i]) meas(rows[i]);
    $display("test rows done");
    // end pulse outside a measurement changes nothing
    @(posedge sys_clk);
    err_src   <= '1;
    cycle_end <= 1'b1;
    @(posedge sys_clk);
    cycle_end <= 1'b0;
    err_src   <= '0;
    repeat (6) @(posedge sys_clk);
    check("status_q", 32'h0, status_q);
    check("ready_q", 32'h1, {31'h0, ready_q});
    $display("test stray end done");
    // measured data and area edges
    @(posedge sys_clk);
    data_we   <= 1'b1;
    data_byte <= 8'h5A;
    @(posedge sys_clk);
    data_we <= 1'b0;
    area(8'h9A, 8'h5A, 1'b0);
    area(8'h99, 8'h00, 1'b1);
    area(8'hAC, 8'h00, 1'b1);
    $display("test area done");
    // fixed reply, prompt and slow host, then refused requests
    reply(gas_status_pkg::BCAST_ADDR, 1'b1, gas_status_pkg::RESP_FRAME, 4);
    slow <= 1'b1;
    reply(gas_status_pkg::BCAST_ADDR, 1'b1, gas_status_pkg::RESP_FRAME, 4);
    reply(8'h01, 1'b1, 32'h0, 0);
    reply(gas_status_pkg::BCAST_ADDR, 1'b0, 32'h0, 0);
    $display("test reply done");
    // fatal error, power cycle, fresh start
    meas(rows[0]);
    @(posedge sys_clk);
    resetn <= 1'b0;
    #1;
    check("status_q", 32'h0, status_q);
    check("ready_q", 32'h0, {31'h0, ready_q});
    @(posedge sys_clk);
    resetn <= 1'b1;
    meas(rows[12]);
    $display("test restart done");
    final_report();
  end
endmodule
